// ### pkg/cpcfg_pkg.sv
// constants, region map and helpers for the code-protection configuration block
package cpcfg_pkg;

   // ==========================================================
   // widths
   localparam int CPCFG_REG_AW  = 22;
   localparam int CPCFG_PROG_AW = 21;

   // ==========================================================
   // configuration-space byte addresses
   localparam logic [21:0] CPCFG_LOW_ADDR  = 22'h300008;
   localparam logic [21:0] CPCFG_HIGH_ADDR = 22'h300009;
   localparam logic [21:0] CPCFG_STAT_ADDR = 22'h300010;

   // ==========================================================
   // field positions
   localparam int CPCFG_BLK0_BIT = 0;
   localparam int CPCFG_BLK1_BIT = 1;
   localparam int CPCFG_BLK2_BIT = 2;
   localparam int CPCFG_BLK3_BIT = 3;
   localparam int CPCFG_BOOT_BIT = 6;
   localparam int CPCFG_EEP_BIT  = 7;

   // implemented bits and unprogrammed values
   localparam logic [7:0] CPCFG_LOW_MASK  = 8'h0F;
   localparam logic [7:0] CPCFG_HIGH_MASK = 8'hC0;
   localparam logic [7:0] CPCFG_LOW_RST   = 8'h0F;
   localparam logic [7:0] CPCFG_HIGH_RST  = 8'hC0;
   localparam logic [7:0] CPCFG_SMALL_FIX = 8'h0C;

   // ==========================================================
   // program memory regions
   localparam logic [20:0] CPCFG_BOOT_LO = 21'h000000;
   localparam logic [20:0] CPCFG_BOOT_HI = 21'h0007FF;
   localparam logic [20:0] CPCFG_BLK0_LO = 21'h000800;
   localparam logic [20:0] CPCFG_BLK0_HI = 21'h001FFF;
   localparam logic [20:0] CPCFG_BLK1_LO = 21'h002000;
   localparam logic [20:0] CPCFG_BLK1_HI = 21'h003FFF;
   localparam logic [20:0] CPCFG_BLK2_LO = 21'h004000;
   localparam logic [20:0] CPCFG_BLK2_HI = 21'h005FFF;
   localparam logic [20:0] CPCFG_BLK3_LO = 21'h006000;
   localparam logic [20:0] CPCFG_BLK3_HI = 21'h007FFF;

   typedef enum logic [6:0] {
      CPCFG_RG_BOOT = 7'h01,
      CPCFG_RG_BLK0 = 7'h02,
      CPCFG_RG_BLK1 = 7'h04,
      CPCFG_RG_BLK2 = 7'h08,
      CPCFG_RG_BLK3 = 7'h10,
      CPCFG_RG_EEP  = 7'h20,
      CPCFG_RG_NONE = 7'h40
   } cpcfg_region_t;

   function automatic logic cpcfg_in_range(input logic [20:0] a, input logic [20:0] lo,
                                           input logic [20:0] hi);
      cpcfg_in_range = (a >= lo) && (a <= hi);
   endfunction

endpackage

// ### verilog/cpcfg_region_check.sv
// region decode and protect decision for one memory access
`timescale 1ns/1ps
module cpcfg_region_check
   import cpcfg_pkg::*;
(
   input  wire logic [20:0]   addr_in,      // program memory address
   input  wire logic          eeprom_in,    // access targets data eeprom
   input  wire logic [7:0]    low_in,       // low protect byte
   input  wire logic [7:0]    high_in,      // high protect byte
   output cpcfg_region_t      region_out,   // one-hot region
   output logic               protect_out   // region is code-protected
);

   // ==========================================================
   // decode
   always_comb begin
      if (eeprom_in) begin
         region_out  = CPCFG_RG_EEP;
         protect_out = !high_in[CPCFG_EEP_BIT];
      end else if (cpcfg_in_range(addr_in, CPCFG_BOOT_LO, CPCFG_BOOT_HI)) begin
         region_out  = CPCFG_RG_BOOT;
         protect_out = !high_in[CPCFG_BOOT_BIT];
      end else if (cpcfg_in_range(addr_in, CPCFG_BLK0_LO, CPCFG_BLK0_HI)) begin
         region_out  = CPCFG_RG_BLK0;
         protect_out = !low_in[CPCFG_BLK0_BIT];
      end else if (cpcfg_in_range(addr_in, CPCFG_BLK1_LO, CPCFG_BLK1_HI)) begin
         region_out  = CPCFG_RG_BLK1;
         protect_out = !low_in[CPCFG_BLK1_BIT];
      end else if (cpcfg_in_range(addr_in, CPCFG_BLK2_LO, CPCFG_BLK2_HI)) begin
         region_out  = CPCFG_RG_BLK2;
         protect_out = !low_in[CPCFG_BLK2_BIT];
      end else if (cpcfg_in_range(addr_in, CPCFG_BLK3_LO, CPCFG_BLK3_HI)) begin
         region_out  = CPCFG_RG_BLK3;
         protect_out = !low_in[CPCFG_BLK3_BIT];
      end else begin
         // above the covered blocks nothing is protected
         region_out  = CPCFG_RG_NONE;
         protect_out = 1'b0;
      end
   end

endmodule // cpcfg_region_check

// ### verilog/cpcfg_top.sv
// code-protection configuration bytes and access gate for program and eeprom memory
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
// Overview of operation
// - block 0 protected when low bit 0 clear
// - block 1 protected when low bit 1 clear
// - block 2 protected when low bit 2 clear
// - block 3 protected when low bit 3 clear
// - boot block protected when high bit 6 clear
// - data eeprom protected when high bit 7 clear
// - unused bits of both bytes read zero
// - bits read 1 unprogrammed, only clearable
// - bytes live at 300008h and 300009h
module cpcfg_top
   import cpcfg_pkg::*;
#(
   parameter bit SMALL_MEM = 1'b0                 // reduced-memory variant
)(
   input  wire logic          sys_clk_in,         // 40 MHz clock
   input  wire logic          rst_n_in,           // synchronous reset, active low
   input  wire logic [21:0]   reg_addr_in,        // register byte address
   input  wire logic [7:0]    reg_wdata_in,       // register write data
   input  wire logic          reg_wr_in,          // write strobe
   input  wire logic          reg_rd_in,          // read strobe
   output logic [7:0]         reg_rdata_out,      // read data, cycle after strobe
   input  wire logic          bulk_erase_in,      // full device erase pulse
   input  wire logic          acc_valid_in,       // memory access request
   input  wire logic [20:0]   acc_addr_in,        // program memory address
   input  wire logic          acc_eeprom_in,      // request targets data eeprom
   input  wire logic          acc_ext_in,         // request from external reader
   output logic               acc_grant_out,      // access allowed pulse
   output logic               acc_deny_out,       // access refused pulse
   output logic [6:0]         acc_region_out,     // region of last request
   output logic               block0_protect_n_out,      // block 0 protect bit
   output logic               block1_protect_n_out,      // block 1 protect bit
   output logic               block2_protect_n_out,      // block 2 protect bit
   output logic               block3_protect_n_out,      // block 3 protect bit
   output logic               boot_block_protect_n_out,  // boot block protect bit
   output logic               data_eeprom_protect_n_out  // data eeprom protect bit
);

   // ==========================================================
   // local types
   typedef logic [7:0] cpcfg_byte_t;

   // bits that the small variant keeps set whatever is written
   localparam cpcfg_byte_t LOW_FIX = SMALL_MEM ? CPCFG_SMALL_FIX : 8'h00;

   // ==========================================================
   // helper functions
   // true when a byte address selects the low protect byte
   function automatic logic cpcfg_is_low(input logic [21:0] a);
      cpcfg_is_low = (a == CPCFG_LOW_ADDR);
   endfunction

   // true when a byte address selects the high protect byte
   function automatic logic cpcfg_is_high(input logic [21:0] a);
      cpcfg_is_high = (a == CPCFG_HIGH_ADDR);
   endfunction

   // a write can only clear implemented bits; ones in the data leave a bit alone
   function automatic cpcfg_byte_t cpcfg_clear_only(input cpcfg_byte_t cur,
                                                    input cpcfg_byte_t wdata,
                                                    input cpcfg_byte_t mask,
                                                    input cpcfg_byte_t fix);
      cpcfg_clear_only = ((cur & wdata) | fix) & mask;
   endfunction

   // what a read returns for one address; holes and unused bits read zero
   function automatic cpcfg_byte_t cpcfg_read_mux(input logic [21:0] a,
                                                  input cpcfg_byte_t lo,
                                                  input cpcfg_byte_t hi);
      if (cpcfg_is_low(a)) begin
         cpcfg_read_mux = lo & CPCFG_LOW_MASK;
      end else if (cpcfg_is_high(a)) begin
         cpcfg_read_mux = hi & CPCFG_HIGH_MASK;
      end else begin
         cpcfg_read_mux = 8'h00;
      end
   endfunction

   // ==========================================================
   // stored protect bytes
   // reset stands for the arrival of a blank part; a real array keeps its
   // contents across reset, so a mid-run reset here acts like a full erase
   cpcfg_byte_t low_q;
   cpcfg_byte_t low_d;
   cpcfg_byte_t high_q;
   cpcfg_byte_t high_d;
   logic        low_wr;
   logic        high_wr;

   assign low_wr  = reg_wr_in && cpcfg_is_low(reg_addr_in);
   assign high_wr = reg_wr_in && cpcfg_is_high(reg_addr_in);

   // erase wins over a write in the same cycle: erase or reset is the only way back to 1
   always_comb begin
      low_d  = low_q;
      high_d = high_q;
      if (bulk_erase_in) begin
         low_d  = CPCFG_LOW_RST | LOW_FIX;
         high_d = CPCFG_HIGH_RST;
      end else begin
         if (low_wr) begin
            low_d = cpcfg_clear_only(low_q, reg_wdata_in, CPCFG_LOW_MASK, LOW_FIX);
         end
         if (high_wr) begin
            high_d = cpcfg_clear_only(high_q, reg_wdata_in, CPCFG_HIGH_MASK, 8'h00);
         end
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         low_q <= CPCFG_LOW_RST | LOW_FIX;
      end else begin
         low_q <= low_d;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         high_q <= CPCFG_HIGH_RST;
      end else begin
         high_q <= high_d;
      end
   end

   // ==========================================================
   // protect bit outputs, straight from the stored bytes
   assign block0_protect_n_out      = low_q[CPCFG_BLK0_BIT];
   assign block1_protect_n_out      = low_q[CPCFG_BLK1_BIT];
   assign block2_protect_n_out      = low_q[CPCFG_BLK2_BIT];
   assign block3_protect_n_out      = low_q[CPCFG_BLK3_BIT];
   assign boot_block_protect_n_out  = high_q[CPCFG_BOOT_BIT];
   assign data_eeprom_protect_n_out = high_q[CPCFG_EEP_BIT];

   // ==========================================================
   // register read port
   cpcfg_byte_t rdata_q;

   // data stand for exactly one cycle after the strobe and read zero otherwise
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         rdata_q <= 8'h00;
      end else if (reg_rd_in) begin
         rdata_q <= cpcfg_read_mux(reg_addr_in, low_q, high_q);
      end else begin
         rdata_q <= 8'h00;
      end
   end

   assign reg_rdata_out = rdata_q;

   // ==========================================================
   // access gate
   cpcfg_region_t rc_region;
   logic          rc_protect;
   logic          grant_d;
   logic          deny_d;
   logic          grant_q;
   logic          deny_q;
   cpcfg_region_t region_q;

   // the decision uses the bytes as they stand now, never a copy taken earlier
   cpcfg_region_check cpcfg_region_check_inst (
      .addr_in     (acc_addr_in),
      .eeprom_in   (acc_eeprom_in),
      .low_in      (low_q),
      .high_in     (high_q),
      .region_out  (rc_region),
      .protect_out (rc_protect)
   );

   // protection only keeps out external readers; code running inside the part
   // may still fetch from its own protected blocks
   always_comb begin
      grant_d = 1'b0;
      deny_d  = 1'b0;
      if (acc_valid_in) begin
         if (acc_ext_in && rc_protect) begin
            deny_d  = 1'b1;
         end else begin
            grant_d = 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         grant_q <= 1'b0;
      end else begin
         grant_q <= grant_d;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         deny_q <= 1'b0;
      end else begin
         deny_q <= deny_d;
      end
   end

   // the region is held from the last request so software can see what was refused
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         region_q <= CPCFG_RG_NONE;
      end else if (acc_valid_in) begin
         region_q <= rc_region;
      end
   end

   assign acc_grant_out  = grant_q;
   assign acc_deny_out   = deny_q;
   assign acc_region_out = region_q;

   // ==========================================================
   // assertions
   a_grant_deny_excl:
      assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
         !(grant_q && deny_q))
      else $error("grant and deny high together");

   a_request_answered:
      assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
         acc_valid_in
         |=> (grant_q || deny_q))
      else $error("access request left unanswered");

   a_deny_when_protected:
      assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
         deny_q
         |-> ($past(acc_valid_in) && $past(acc_ext_in) && $past(rc_protect)))
      else $error("access refused without protection");

   a_grant_when_allowed:
      assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
         grant_q
         |-> ($past(acc_valid_in) && !($past(acc_ext_in) && $past(rc_protect))))
      else $error("protected access granted");

   // holding the region lets a refused request be inspected afterwards
   a_region_hold:
      assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
         ($past(rst_n_in) && !$past(acc_valid_in))
         |-> (region_q == $past(region_q)))
      else $error("region changed without a request");

   a_boot_deny_bit:
      assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
         (deny_q && (region_q == CPCFG_RG_BOOT))
         |-> !$past(high_q[CPCFG_BOOT_BIT]))
      else $error("boot block refused while unprotected");

   a_blk0_deny_bit:
      assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
         (deny_q && (region_q == CPCFG_RG_BLK0))
         |-> !$past(low_q[CPCFG_BLK0_BIT]))
      else $error("block 0 refused while unprotected");

   a_blk1_deny_bit:
      assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
         (deny_q && (region_q == CPCFG_RG_BLK1))
         |-> !$past(low_q[CPCFG_BLK1_BIT]))
      else $error("block 1 refused while unprotected");

   a_blk2_deny_bit:
      assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
         (deny_q && (region_q == CPCFG_RG_BLK2))
         |-> !$past(low_q[CPCFG_BLK2_BIT]))
      else $error("block 2 refused while unprotected");

   a_blk3_deny_bit:
      assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
         (deny_q && (region_q == CPCFG_RG_BLK3))
         |-> !$past(low_q[CPCFG_BLK3_BIT]))
      else $error("block 3 refused while unprotected");

   a_eep_deny_bit:
      assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
         (deny_q && (region_q == CPCFG_RG_EEP))
         |-> !$past(high_q[CPCFG_EEP_BIT]))
      else $error("data eeprom refused while unprotected");

   // stored bytes may only lose ones, except through erase or reset
   a_low_no_set:
      assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
         ($past(rst_n_in) && !$past(bulk_erase_in))
         |-> ((low_q & ~$past(low_q)) == 8'h00))
      else $error("low protect bit set without erase");

   a_high_no_set:
      assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
         ($past(rst_n_in) && !$past(bulk_erase_in))
         |-> ((high_q & ~$past(high_q)) == 8'h00))
      else $error("high protect bit set without erase");

   a_erase_restores:
      assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
         $past(bulk_erase_in)
         |-> ((low_q == (CPCFG_LOW_RST | LOW_FIX)) && (high_q == CPCFG_HIGH_RST)))
      else $error("erase did not restore the protect bytes");

   a_low_unused_store:
      assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
         ((low_q & ~CPCFG_LOW_MASK) == 8'h00))
      else $error("unused low bits not zero");

   a_high_unused_store:
      assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
         ((high_q & ~CPCFG_HIGH_MASK) == 8'h00))
      else $error("unused high bits not zero");

   a_low_read_map:
      assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
         ($past(rst_n_in) && $past(reg_rd_in) && ($past(reg_addr_in) == CPCFG_LOW_ADDR))
         |-> (reg_rdata_out == ($past(low_q) & CPCFG_LOW_MASK)))
      else $error("low byte read returned wrong data");

   a_high_read_map:
      assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
         ($past(rst_n_in) && $past(reg_rd_in) && ($past(reg_addr_in) == CPCFG_HIGH_ADDR))
         |-> (reg_rdata_out == ($past(high_q) & CPCFG_HIGH_MASK)))
      else $error("high byte read returned wrong data");

   a_read_idle_zero:
      assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
         !$past(reg_rd_in)
         |-> (reg_rdata_out == 8'h00))
      else $error("read data present without a strobe");

endmodule // cpcfg_top

// ### dv/tb_cpcfg_top.sv
// self-checking bench for the code-protection configuration block
`timescale 1ns/1ps
module tb_cpcfg_top;
   import cpcfg_pkg::*;
   logic        clk = 0, rst_n = 0, wr = 0, rd = 0, er = 0, av = 0, ae = 0, ext = 0, x, gnt, dny, pend = 0;
   logic [21:0] ra = 0;
   logic [20:0] aa = 0;
   logic [7:0]  wd = 0, rdat, lo = 8'h0F, hi = 8'hC0, v, ea, qr[$], qa[$];
   logic [6:0]  rg;
   logic [5:0]  pb, po;
   int          failures = 0, n_compared = 0, seed = 90754;
   // full-memory part: the bench as programmer may clear the block 2 and 3 bits freely
   cpcfg_top cpcfg_top_inst (.sys_clk_in(clk), .rst_n_in(rst_n),
      .reg_addr_in(ra), .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdat),
      .bulk_erase_in(er), .acc_valid_in(av), .acc_addr_in(aa), .acc_eeprom_in(ae), .acc_ext_in(ext),
      .acc_grant_out(gnt), .acc_deny_out(dny), .acc_region_out(rg), .block0_protect_n_out(po[1]),
      .block1_protect_n_out(po[2]), .block2_protect_n_out(po[3]), .block3_protect_n_out(po[4]),
      .boot_block_protect_n_out(po[0]), .data_eeprom_protect_n_out(po[5]));
   initial forever #12.5 clk = ~clk;
   task automatic cmp(input logic [7:0] e, input logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %0t exp %h got %h", $time, e, g);
      end
   endtask
   // read data stands only in the cycle after the strobe
   always @(negedge clk) begin
      if (pend) cmp(qr.pop_front(), rdat);
      pend = rd;
      if (gnt === 1'b1 || dny === 1'b1) begin
         ea = qa.pop_front();
         cmp(ea, {gnt, rg});
         cmp({7'h00, ~ea[7]}, {7'h00, dny});
      end
   end
   task automatic wr_reg(input logic [21:0] a, input logic [7:0] d);
      @(posedge clk); ra <= a; wd <= d; wr <= 1'b1;
      @(posedge clk); wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [21:0] a, input logic [7:0] e);
      qr.push_back(e);
      @(posedge clk); ra <= a; rd <= 1'b1;
      @(posedge clk); rd <= 1'b0;
   endtask
   // one access per region; base of block i is derived, not looked up
   task automatic sweep();
      pb = {hi[7], lo[3:0], hi[6]};
      for (int i = 0; i < 6; i++) begin
         // internal fetches pass whatever the bits say; only external ones are gated
         x = 1'($random(seed));
         qa.push_back({pb[i] | ~x, 7'h01 << i});
         @(posedge clk);
         av <= 1'b1;
         ae <= (i == 5);
         ext <= x;
         aa <= 21'((i < 2) ? i * 'h800 : (i - 1) * 'h2000) + 21'($random(seed) & 'h7FF);
         @(posedge clk);
         av <= 1'b0;
         repeat (3) @(posedge clk);
      end
      cmp({2'h0, pb}, {2'h0, po});
   endtask
   task automatic summarize();
      repeat (4) @(posedge clk);
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      #(3000 * 25);
      failures++;
      summarize();
   end
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) begin
         rd_reg(CPCFG_LOW_ADDR, lo);
         rd_reg(CPCFG_HIGH_ADDR, hi);
         sweep();
         // biased to ones so bits clear one by one; ones must never set a bit back
         repeat (5) begin
            v = 8'($random(seed) | $random(seed));
            wr_reg(CPCFG_LOW_ADDR, v);
            wr_reg(CPCFG_HIGH_ADDR, {v[3:0], v[7:4]});
            wr_reg(22'h30000A, 8'h00);
            lo = lo & v;
            hi = hi & {v[3:0], v[7:4]};
            rd_reg(CPCFG_LOW_ADDR, lo);
            rd_reg(CPCFG_HIGH_ADDR, hi);
            rd_reg(22'h30000A, 8'h00);
            sweep();
         end
         @(posedge clk); er <= 1'b1;
         @(posedge clk); er <= 1'b0;
         repeat (3) @(posedge clk);
         lo = 8'h0F;
         hi = 8'hC0;
      end
      summarize();
   end
endmodule // tb_cpcfg_top
